// ===== design/pimc_pkg.sv
// Shared constants and carrier types for the port, interrupt and crossbar block.
package pimc_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int SEL_W  = 3;
  localparam int CAP_N  = 6;
  localparam int SPIA_W = 3;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT0     = 8'h80;
  localparam logic [7:0] ADDR_PORT1     = 8'h90;
  localparam logic [7:0] ADDR_TIMER_CTL = 8'h88;
  localparam logic [7:0] ADDR_IRQ_CFG   = 8'he4;
  localparam logic [7:0] ADDR_CMP_SEL0  = 8'hc7;
  localparam logic [7:0] ADDR_EXP_VAL0  = 8'hd7;
  localparam logic [7:0] ADDR_CMP_SEL1  = 8'hbf;
  localparam logic [7:0] ADDR_EXP_VAL1  = 8'hcf;
  localparam logic [7:0] ADDR_XBAR_A    = 8'he1;
  localparam logic [7:0] ADDR_XBAR_B    = 8'hf2;
  localparam logic [7:0] ADDR_XBAR_C    = 8'he3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LATCH   = 8'hff;
  localparam logic [7:0] RST_CMP_SEL = 8'h00;
  localparam logic [7:0] RST_EXP_VAL = 8'hff;
  localparam logic [7:0] RST_XBAR    = 8'h00;
  localparam logic [7:0] RST_IRQ_CFG = 8'h00;
  localparam logic [7:0] ALL_ONES    = 8'hff;
  localparam logic [7:0] ALL_ZERO    = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TC_SENSE_A = 0;
  localparam int TC_PEND_A  = 1;
  localparam int TC_SENSE_B = 2;
  localparam int TC_PEND_B  = 3;
  localparam int CFG_SEL_A  = 0;
  localparam int CFG_POL_A  = 3;
  localparam int CFG_SEL_B  = 4;
  localparam int CFG_POL_B  = 7;
  localparam int XA_UART    = 0;
  localparam int XA_SPI_A   = 1;
  localparam int XB_SPI_B   = 6;
  localparam int XB_CAP_LSB = 0;
  localparam int XC_PULLOFF = 7;
  localparam int XC_MASTER  = 6;
  localparam logic [7:0] XC_WR_MASK = 8'hc0;
  localparam int PIN_UART_TX  = 4;
  localparam int PIN_UART_RX  = 5;
  localparam int PIN_SPIB_SCK = 0;
  localparam int PIN_SPIB_MISO = 1;
  localparam int PIN_SPIB_MOSI = 2;
  localparam int PIN_SPIB_NSS  = 3;
  localparam logic [2:0] SPIA_PINS_3 = 3'h3;
  localparam logic [2:0] SPIA_PINS_4 = 3'h4;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic              rd;
    logic              rmw;
    logic [7:0]        wdata;
  } pimc_sfr_req_t;

  typedef struct packed {
    logic uart_tx;
    logic spi_a_nss_out;
    logic spi_b_sck;
    logic spi_b_mosi;
    logic spi_b_nss;
    logic spi_b_four_wire;
  } pimc_periph_t;

  typedef struct packed {
    logic [PORT_W-1:0] p0_s1;
    logic [PORT_W-1:0] p0_s2;
    logic [PORT_W-1:0] p1_s1;
    logic [PORT_W-1:0] p1_s2;
    logic              prev_a;
    logic              prev_b;
    logic              pend_a;
    logic              pend_b;
    logic              sense_a;
    logic              sense_b;
    logic [PORT_W-1:0] latch0;
    logic [PORT_W-1:0] latch1;
    logic [PORT_W-1:0] mask0;
    logic [PORT_W-1:0] mat0;
    logic [PORT_W-1:0] mask1;
    logic [PORT_W-1:0] mat1;
    logic [7:0]        xbr_a;
    logic [7:0]        xbr_b;
    logic [7:0]        xbr_c;
    logic [7:0]        irq_cfg;
    logic [7:0]        rdata;
    logic [PORT_W-1:0] p0_out;
    logic [PORT_W-1:0] p0_oe_n;
    logic [PORT_W-1:0] p1_out;
    logic [PORT_W-1:0] p1_oe_n;
    logic              mismatch;
    logic              uart_rx;
    logic              spi_b_miso;
    logic [CAP_N-1:0]  cap_route;
    logic [SPIA_W-1:0] spi_a_pins;
  } pimc_state_t;
endpackage

// ===== design/pimc_top.sv
// Port latches, external pin interrupts, port mismatch and crossbar enables.
`timescale 1ns/10ps

// Summary of operation
// RQ1 - Edge mode interrupts on falling edge at polarity 0, rising at 1.
// RQ2 - Level mode requests while input low at polarity 0, high at 1.
// RQ3 - Both interrupts pick any port 0 pin, only observing it.
// RQ4 - Edge mode pending flag clears when the processor vectors to it.
// RQ5 - Level mode pending flag simply mirrors the active input level.
// RQ6 - Level source holds request until recognised, drops before routine ends.
// RQ7 - Mismatch when masked pins differ from masked expected values.
// RQ8 - Mismatch drives interrupt and wake-up, regardless of crossbar settings.
// RQ9 - Compare-select bit 1 includes pin, 0 excludes; reset to 0.
// RQ10 - Port write stores value in the output latch driving pins.
// RQ11 - Normal port read returns pin levels, even for crossbar-owned pins.
// RQ12 - Read-modify-write port reads return the latch instead of pins.
// RQ13 - First crossbar register holds eight peripheral routing enables.
// RQ14 - UART routing puts transmit on P0.4 and receive on P0.5.
// RQ15 - First SPI takes three or four pins depending on slave select.
// RQ16 - Second SPI uses P1.0 to P1.3; select only in 4-wire.
// RQ17 - Second register bits 6 to 3 route SPI, timers, count input.
// RQ18 - Bits 2:0 route capture channels 0 to n-1; zero routes none.
// RQ19 - Third register bit 7 set disables all weak pullups.
// RQ20 - Third register bit 6 is crossbar master enable, reset 0.
// RQ21 - Master enable clear disables every port output driver.
// RQ22 - Expected-value bit 0 compares low, 1 compares high; reset 1.
// RQ23 - Pin inputs pass two flip-flops before any logic uses them.
// RQ24 - Edge detect compares current and previous synchronised samples.
module pimc_top (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  // Special function register access
  input  wire pimc_pkg::pimc_sfr_req_t      sfr_req,
  output logic [7:0]                        sfr_rdata,
  // Interrupt vectoring acknowledges
  input  wire logic                         irq_a_ack,
  input  wire logic                         irq_b_ack,
  // Pins
  input  wire logic [pimc_pkg::PORT_W-1:0]  p0_in,
  input  wire logic [pimc_pkg::PORT_W-1:0]  p1_in,
  output logic [pimc_pkg::PORT_W-1:0]       p0_out,
  output logic [pimc_pkg::PORT_W-1:0]       p0_oe_n,
  output logic [pimc_pkg::PORT_W-1:0]       p1_out,
  output logic [pimc_pkg::PORT_W-1:0]       p1_oe_n,
  // Peripheral side
  input  wire pimc_pkg::pimc_periph_t       periph,
  output logic                              uart_rx,
  output logic                              spi_b_miso,
  // Events and routing state
  output logic                              irq_a_req,
  output logic                              irq_b_req,
  output logic                              port_mismatch,
  output logic [7:0]                        crossbar_route_a,
  output logic [7:0]                        crossbar_route_b,
  output logic                              pullup_global_off,
  output logic                              crossbar_master_enable,
  output logic [pimc_pkg::CAP_N-1:0]        capture_out_route,
  output logic [pimc_pkg::SPIA_W-1:0]       spi_a_pin_count
);
  pimc_pkg::pimc_state_t q;
  pimc_pkg::pimc_state_t d;

  // ----------------------------------------------------------------
  // Derived views of the configuration and synchronised pins
  // ----------------------------------------------------------------
  logic [pimc_pkg::SEL_W-1:0] sel_a;
  logic [pimc_pkg::SEL_W-1:0] sel_b;
  logic                       pol_a;
  logic                       pol_b;
  logic                       cur_a;
  logic                       cur_b;
  logic                       act_a;
  logic                       act_b;
  logic                       edge_a;
  logic                       edge_b;
  logic                       cmp_miss;
  logic                       xbar_on;

  assign sel_a   = q.irq_cfg[pimc_pkg::CFG_SEL_A +: pimc_pkg::SEL_W];
  assign sel_b   = q.irq_cfg[pimc_pkg::CFG_SEL_B +: pimc_pkg::SEL_W];
  assign pol_a   = q.irq_cfg[pimc_pkg::CFG_POL_A];
  assign pol_b   = q.irq_cfg[pimc_pkg::CFG_POL_B];
  // Tapping the synchronised copy leaves the pin's owner undisturbed.
  assign cur_a   = q.p0_s2[sel_a]; // see RQ3
  assign cur_b   = q.p0_s2[sel_b]; // see RQ3
  assign act_a   = pol_a ? cur_a : ~cur_a; // see RQ2
  assign act_b   = pol_b ? cur_b : ~cur_b; // see RQ2
  // Active-going transition between previous and current sample.
  assign edge_a  = act_a & ~(pol_a ? q.prev_a : ~q.prev_a); // see RQ1, RQ24
  assign edge_b  = act_b & ~(pol_b ? q.prev_b : ~q.prev_b); // see RQ1, RQ24
  assign cmp_miss = ((q.p0_s2 & q.mask0) != (q.mat0 & q.mask0)) ||
                    ((q.p1_s2 & q.mask1) != (q.mat1 & q.mask1)); // see RQ7
  assign xbar_on = q.xbr_c[pimc_pkg::XC_MASTER];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic wr_tc;
    wr_tc = sfr_req.wr && (sfr_req.addr == pimc_pkg::ADDR_TIMER_CTL);
    d = q;
    d.p0_s1  = p0_in; // see RQ23
    d.p0_s2  = q.p0_s1;
    d.p1_s1  = p1_in;
    d.p1_s2  = q.p1_s1;
    d.prev_a = cur_a;
    d.prev_b = cur_b;

    // Register writes.
    if (sfr_req.wr) begin
      case (sfr_req.addr)
        pimc_pkg::ADDR_PORT0:    d.latch0 = sfr_req.wdata; // see RQ10
        pimc_pkg::ADDR_PORT1:    d.latch1 = sfr_req.wdata; // see RQ10
        pimc_pkg::ADDR_CMP_SEL0: d.mask0  = sfr_req.wdata; // see RQ9
        pimc_pkg::ADDR_EXP_VAL0: d.mat0   = sfr_req.wdata; // see RQ22
        pimc_pkg::ADDR_CMP_SEL1: d.mask1  = sfr_req.wdata;
        pimc_pkg::ADDR_EXP_VAL1: d.mat1   = sfr_req.wdata;
        pimc_pkg::ADDR_XBAR_A:   d.xbr_a  = sfr_req.wdata; // see RQ13
        pimc_pkg::ADDR_XBAR_B:   d.xbr_b  = sfr_req.wdata; // see RQ17
        pimc_pkg::ADDR_XBAR_C:
          d.xbr_c = sfr_req.wdata & pimc_pkg::XC_WR_MASK; // see RQ19, RQ20
        pimc_pkg::ADDR_IRQ_CFG:  d.irq_cfg = sfr_req.wdata;
        pimc_pkg::ADDR_TIMER_CTL: begin
          d.sense_a = sfr_req.wdata[pimc_pkg::TC_SENSE_A];
          d.sense_b = sfr_req.wdata[pimc_pkg::TC_SENSE_B];
        end
        default: d.latch0 = q.latch0;
      endcase
    end

    // Pending flags; a fresh edge wins over acknowledge or software clear.
    if (!q.sense_a) begin
      d.pend_a = act_a; // see RQ5, RQ2
    end else if (edge_a) begin
      d.pend_a = 1'b1; // see RQ1
    end else if (irq_a_ack) begin
      d.pend_a = 1'b0; // see RQ4
    end else if (wr_tc) begin
      d.pend_a = sfr_req.wdata[pimc_pkg::TC_PEND_A];
    end
    if (!q.sense_b) begin
      d.pend_b = act_b; // see RQ5, RQ2
    end else if (edge_b) begin
      d.pend_b = 1'b1; // see RQ1
    end else if (irq_b_ack) begin
      d.pend_b = 1'b0; // see RQ4
    end else if (wr_tc) begin
      d.pend_b = sfr_req.wdata[pimc_pkg::TC_PEND_B];
    end

    d.mismatch = cmp_miss; // see RQ7, RQ8

    // Read data: pins normally, latch for read-modify-write.
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        pimc_pkg::ADDR_PORT0:
          d.rdata = sfr_req.rmw ? q.latch0 : q.p0_s2; // see RQ11, RQ12
        pimc_pkg::ADDR_PORT1:
          d.rdata = sfr_req.rmw ? q.latch1 : q.p1_s2; // see RQ11, RQ12
        pimc_pkg::ADDR_CMP_SEL0:  d.rdata = q.mask0;
        pimc_pkg::ADDR_EXP_VAL0:  d.rdata = q.mat0;
        pimc_pkg::ADDR_CMP_SEL1:  d.rdata = q.mask1;
        pimc_pkg::ADDR_EXP_VAL1:  d.rdata = q.mat1;
        pimc_pkg::ADDR_XBAR_A:    d.rdata = q.xbr_a;
        pimc_pkg::ADDR_XBAR_B:    d.rdata = q.xbr_b;
        pimc_pkg::ADDR_XBAR_C:    d.rdata = q.xbr_c;
        pimc_pkg::ADDR_IRQ_CFG:   d.rdata = q.irq_cfg;
        pimc_pkg::ADDR_TIMER_CTL: begin
          d.rdata = pimc_pkg::ALL_ZERO;
          d.rdata[pimc_pkg::TC_SENSE_A] = q.sense_a;
          d.rdata[pimc_pkg::TC_PEND_A]  = q.pend_a;
          d.rdata[pimc_pkg::TC_SENSE_B] = q.sense_b;
          d.rdata[pimc_pkg::TC_PEND_B]  = q.pend_b;
        end
        default: d.rdata = pimc_pkg::ALL_ZERO;
      endcase
    end

    // Pin drivers: the latch acts open-drain, peripherals override.
    d.p0_out  = q.latch0;
    d.p1_out  = q.latch1;
    d.p0_oe_n = q.latch0;
    d.p1_oe_n = q.latch1;
    if (q.xbr_a[pimc_pkg::XA_UART]) begin
      d.p0_out[pimc_pkg::PIN_UART_TX]  = periph.uart_tx; // see RQ14
      d.p0_oe_n[pimc_pkg::PIN_UART_TX] = 1'b0;
      d.p0_oe_n[pimc_pkg::PIN_UART_RX] = 1'b1;
    end
    if (q.xbr_b[pimc_pkg::XB_SPI_B]) begin
      d.p1_out[pimc_pkg::PIN_SPIB_SCK]   = periph.spi_b_sck; // see RQ16
      d.p1_oe_n[pimc_pkg::PIN_SPIB_SCK]  = 1'b0;
      d.p1_oe_n[pimc_pkg::PIN_SPIB_MISO] = 1'b1;
      d.p1_out[pimc_pkg::PIN_SPIB_MOSI]  = periph.spi_b_mosi;
      d.p1_oe_n[pimc_pkg::PIN_SPIB_MOSI] = 1'b0;
      if (periph.spi_b_four_wire) begin
        d.p1_out[pimc_pkg::PIN_SPIB_NSS]  = periph.spi_b_nss;
        d.p1_oe_n[pimc_pkg::PIN_SPIB_NSS] = 1'b0;
      end
    end
    if (!xbar_on) begin
      d.p0_oe_n = pimc_pkg::ALL_ONES; // see RQ21
      d.p1_oe_n = pimc_pkg::ALL_ONES; // see RQ21
    end
    d.uart_rx    = q.p0_s2[pimc_pkg::PIN_UART_RX];
    d.spi_b_miso = q.p1_s2[pimc_pkg::PIN_SPIB_MISO];

    // Channel i routed when the field value exceeds i.
    for (int i = 0; i < pimc_pkg::CAP_N; i++) begin
      d.cap_route[i] = (q.xbr_b[pimc_pkg::XB_CAP_LSB +: 3] >
                        3'(i)); // see RQ18
    end
    if (!q.xbr_a[pimc_pkg::XA_SPI_A]) begin
      d.spi_a_pins = '0;
    end else if (periph.spi_a_nss_out) begin
      d.spi_a_pins = pimc_pkg::SPIA_PINS_4; // see RQ15
    end else begin
      d.spi_a_pins = pimc_pkg::SPIA_PINS_3; // see RQ15
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q         <= '0;
      q.latch0  <= pimc_pkg::RST_LATCH;
      q.latch1  <= pimc_pkg::RST_LATCH;
      q.mask0   <= pimc_pkg::RST_CMP_SEL; // see RQ9
      q.mask1   <= pimc_pkg::RST_CMP_SEL;
      q.mat0    <= pimc_pkg::RST_EXP_VAL; // see RQ22
      q.mat1    <= pimc_pkg::RST_EXP_VAL;
      q.xbr_a   <= pimc_pkg::RST_XBAR;
      q.xbr_b   <= pimc_pkg::RST_XBAR;
      q.xbr_c   <= pimc_pkg::RST_XBAR; // see RQ20
      q.irq_cfg <= pimc_pkg::RST_IRQ_CFG;
      q.p0_out  <= pimc_pkg::RST_LATCH;
      q.p1_out  <= pimc_pkg::RST_LATCH;
      q.p0_oe_n <= pimc_pkg::ALL_ONES;
      q.p1_oe_n <= pimc_pkg::ALL_ONES;
      // Synchronisers start at the pulled-up idle level, so no false edge.
      q.p0_s1   <= pimc_pkg::ALL_ONES;
      q.p0_s2   <= pimc_pkg::ALL_ONES;
      q.p1_s1   <= pimc_pkg::ALL_ONES;
      q.p1_s2   <= pimc_pkg::ALL_ONES;
      q.prev_a  <= 1'b1;
      q.prev_b  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sfr_rdata              = q.rdata;
  assign p0_out                 = q.p0_out;
  assign p0_oe_n                = q.p0_oe_n;
  assign p1_out                 = q.p1_out;
  assign p1_oe_n                = q.p1_oe_n;
  assign uart_rx                = q.uart_rx;
  assign spi_b_miso             = q.spi_b_miso;
  assign irq_a_req              = q.pend_a;
  assign irq_b_req              = q.pend_b;
  assign port_mismatch          = q.mismatch;
  assign crossbar_route_a       = q.xbr_a;
  assign crossbar_route_b       = q.xbr_b;
  assign pullup_global_off      = q.xbr_c[pimc_pkg::XC_PULLOFF]; // see RQ19
  assign crossbar_master_enable = q.xbr_c[pimc_pkg::XC_MASTER];
  assign capture_out_route      = q.cap_route;
  assign spi_a_pin_count        = q.spi_a_pins;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_edge_sets_pend: assert property ( // see RQ1
    q.sense_a && edge_a |=> q.pend_a)
    else $error("edge did not set pending flag a");
  a_level_mirrors: assert property ( // see RQ5
    !q.sense_a && !$past(sys_rst) |=> q.pend_a == $past(act_a))
    else $error("level pending flag a does not follow input");
  a_ack_clears: assert property ( // see RQ4
    q.sense_a && irq_a_ack && !edge_a |=> !q.pend_a)
    else $error("acknowledge did not clear pending flag a");
  a_mismatch_eval: assert property ( // see RQ7
    ##1 q.mismatch == $past(cmp_miss))
    else $error("mismatch output wrong");
  a_mask_zero_quiet: assert property ( // see RQ9
    (q.mask0 == '0 && q.mask1 == '0) |=> !q.mismatch)
    else $error("mismatch with all pins excluded");
  a_latch_write: assert property ( // see RQ10
    sfr_req.wr && sfr_req.addr == pimc_pkg::ADDR_PORT0
    |=> q.latch0 == $past(sfr_req.wdata))
    else $error("port latch write lost");
  a_read_pins: assert property ( // see RQ11
    sfr_req.rd && !sfr_req.rmw && sfr_req.addr == pimc_pkg::ADDR_PORT0
    |=> sfr_rdata == $past(q.p0_s2))
    else $error("port read did not return pins");
  a_rmw_latch: assert property ( // see RQ12
    sfr_req.rd && sfr_req.rmw && sfr_req.addr == pimc_pkg::ADDR_PORT1
    |=> sfr_rdata == $past(q.latch1))
    else $error("modify read did not return latch");
  a_drivers_off: assert property ( // see RQ21
    !xbar_on |=> (p0_oe_n == pimc_pkg::ALL_ONES) &&
                 (p1_oe_n == pimc_pkg::ALL_ONES))
    else $error("driver enabled with crossbar off");
  a_uart_pin: assert property ( // see RQ14
    xbar_on && q.xbr_a[pimc_pkg::XA_UART]
    |=> p0_out[pimc_pkg::PIN_UART_TX] == $past(periph.uart_tx))
    else $error("uart transmit not on its pin");
  a_sync_depth: assert property ( // see RQ23
    !$past(sys_rst) && !$past(sys_rst, 2) |-> q.p0_s2 == $past(p0_in, 2))
    else $error("pin synchroniser depth wrong");

  c_edge_irq: cover property (q.sense_a && edge_a ##1 irq_a_ack);
  c_level_irq: cover property (!q.sense_b && act_b ##1 q.pend_b);
  c_mismatch: cover property (!q.mismatch ##1 q.mismatch);
  c_rmw_read: cover property (sfr_req.rd && sfr_req.rmw);
endmodule // pimc_top

// ===== sim/pimc_pin_model.sv
// Far-side pin sources and a level-triggered interrupt source.
`timescale 1ns/10ps
module pimc_pin_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Bench control of the far side
  input  wire logic [7:0] ext0_en,
  input  wire logic [7:0] ext0_lvl,
  input  wire logic [7:0] ext1_en,
  input  wire logic [7:0] ext1_lvl,
  input  wire logic       lvl_start,
  input  wire logic       irq_ack,
  // Device pins
  input  wire logic [7:0] p0_out,
  input  wire logic [7:0] p0_oe_n,
  input  wire logic [7:0] p1_out,
  input  wire logic [7:0] p1_oe_n,
  input  wire logic       pu_off,
  output logic [7:0]      p0_in,
  output logic [7:0]      p1_in
);
  logic       lvl_req_q;
  logic [7:0] last0_q;
  logic [7:0] last1_q;
  logic [7:0] rel0;
  logic [7:0] rel1;
  logic [7:0] drv0;
  logic [7:0] drv1;
  // ----------------------------------------------------------------
  // Pad levels
  // ----------------------------------------------------------------
  // With pullups off a released line shows the inverse of its last
  // level, so a stale value cannot pass for a driven one.
  assign rel0 = pu_off ? ~last0_q : 8'hff;
  assign rel1 = pu_off ? ~last1_q : 8'hff;
  assign drv0 = ext0_en | ~p0_oe_n;
  assign drv1 = ext1_en | ~p1_oe_n;
  // A low from either side wins over the pullup.
  assign p0_in = ~(~p0_oe_n & ~p0_out) & ((ext0_en & ext0_lvl) |
                 (~ext0_en & rel0)) & {7'h7f, ~lvl_req_q};
  assign p1_in = ~(~p1_oe_n & ~p1_out) & ((ext1_en & ext1_lvl) |
                 (~ext1_en & rel1));
  // ----------------------------------------------------------------
  // Level source on P0.0, active low
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    // Only a driven line refreshes the level that a release inverts.
    last0_q <= sys_rst ? 8'hff : (drv0 & p0_in) | (~drv0 & last0_q);
    last1_q <= sys_rst ? 8'hff : (drv1 & p1_in) | (~drv1 & last1_q);
    if (sys_rst || irq_ack) begin
      lvl_req_q <= 1'b0;
    end else if (lvl_start) begin
      lvl_req_q <= 1'b1;
    end
  end
endmodule // pimc_pin_model

// ===== sim/tb_port_irq_match_crossbar.sv
// Self-checking bench for the port, interrupt and crossbar block.
`timescale 1ns/10ps
module tb_port_irq_match_crossbar;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } pimc_tb_row_t;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  pimc_pkg::pimc_sfr_req_t req = '0;
  pimc_pkg::pimc_periph_t  pr = '0;
  logic [7:0] sfr_rdata, p0_in, p1_in, p0_out, p0_oe_n, p1_out, p1_oe_n;
  logic [7:0] ext0_en = 8'h00, ext0_lvl = 8'h00, route_a;
  logic [7:0] ext1_en = 8'h00, ext1_lvl = 8'h00, route_b;
  logic       ack = 1'b0, lvl_start = 1'b0, irq_a_req, mism, pu_off, mst;
  logic       uart_rx, spi_b_miso, irq_b_req;
  logic [5:0] cap;
  logic [2:0] spi_cnt;
  int         miscompares = 0, n_compared = 0, cycles = 0;
  pimc_tb_row_t rows [8];

  always #5 ref_clk = ~ref_clk;

  pimc_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_req(req),
    .sfr_rdata(sfr_rdata), .irq_a_ack(ack), .irq_b_ack(ack),
    .p0_in(p0_in), .p1_in(p1_in), .p0_out(p0_out), .p0_oe_n(p0_oe_n),
    .p1_out(p1_out), .p1_oe_n(p1_oe_n), .periph(pr), .uart_rx(uart_rx),
    .spi_b_miso(spi_b_miso), .irq_a_req(irq_a_req),
    .irq_b_req(irq_b_req), .port_mismatch(mism),
    .crossbar_route_a(route_a),
    .crossbar_route_b(route_b), .pullup_global_off(pu_off),
    .crossbar_master_enable(mst), .capture_out_route(cap),
    .spi_a_pin_count(spi_cnt));

  pimc_pin_model pin_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .ext0_en(ext0_en), .ext0_lvl(ext0_lvl), .ext1_en(ext1_en),
    .ext1_lvl(ext1_lvl), .lvl_start(lvl_start), .irq_ack(ack),
    .p0_out(p0_out), .p0_oe_n(p0_oe_n), .p1_out(p1_out),
    .p1_oe_n(p1_oe_n), .pu_off(pu_off), .p0_in(p0_in), .p1_in(p1_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    cyc(1);
    req.wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(logic [7:0] a, logic m, logic [7:0] e, string w);
    req.addr = a;
    req.rmw = m;
    req.rd = 1'b1;
    cyc(1);
    req.rd = 1'b0;
    req.rmw = 1'b0;
    chk(w, e, sfr_rdata);
    cyc(1);
  endtask
  task automatic pulse_ack();
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    cyc(8);
    sys_rst = 1'b0;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{pimc_pkg::ADDR_XBAR_A, 8'ha5, 8'ha5},
             '{pimc_pkg::ADDR_XBAR_B, 8'h7f, 8'h7f},
             '{pimc_pkg::ADDR_XBAR_C, 8'hff, 8'hc0},
             '{pimc_pkg::ADDR_CMP_SEL0, 8'h3c, 8'h3c},
             '{pimc_pkg::ADDR_EXP_VAL0, 8'h5a, 8'h5a},
             '{pimc_pkg::ADDR_CMP_SEL1, 8'h81, 8'h81},
             '{pimc_pkg::ADDR_EXP_VAL1, 8'h7e, 8'h7e},
             '{8'h55, 8'hff, 8'h00}};
    cyc(1);
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, 1'b0, rows[i].e, "register readback");
    end
    for (int n = 0; n < 8; n++) begin
      wr(pimc_pkg::ADDR_XBAR_B, 8'(n));
      cyc(2);
      chk("capture route", (n > 5) ? 8'h3f : 8'((1 << n) - 1), 8'(cap));
    end
    do_reset();
    rd(pimc_pkg::ADDR_XBAR_C, 1'b0, 8'h00, "route c");
    rd(pimc_pkg::ADDR_CMP_SEL0, 1'b0, 8'h00, "cmp sel");
    rd(pimc_pkg::ADDR_EXP_VAL1, 1'b0, 8'hff, "exp val");
    rd(pimc_pkg::ADDR_PORT0, 1'b1, 8'hff, "latch");
    chk("oe after reset", 8'hff, p0_oe_n);
    ext0_en = 8'h04;
    for (int pol = 0; pol < 2; pol++) begin
      ext0_lvl[2] = ~pol[0];
      wr(pimc_pkg::ADDR_IRQ_CFG, {4'h0, pol[0], 3'h2});
      wr(pimc_pkg::ADDR_TIMER_CTL, 8'h01);
      cyc(4);
      wr(pimc_pkg::ADDR_TIMER_CTL, 8'h01);
      cyc(2);
      chk("edge idle", 8'h00, 8'(irq_a_req));
      ext0_lvl[2] = pol[0];
      cyc(4);
      chk("edge set", 8'h01, 8'(irq_a_req));
      rd(pimc_pkg::ADDR_TIMER_CTL, 1'b0, 8'h03, "flags");
      pulse_ack();
      cyc(1);
      chk("edge ack", 8'h00, 8'(irq_a_req));
      ext0_lvl[2] = ~pol[0];
      cyc(4);
      chk("wrong edge", 8'h00, 8'(irq_a_req));
    end
    wr(pimc_pkg::ADDR_TIMER_CTL, 8'h00);
    wr(pimc_pkg::ADDR_IRQ_CFG, 8'h0a);
    ext0_lvl[2] = 1'b1;
    cyc(4);
    pulse_ack();
    chk("level high", 8'h01, 8'(irq_a_req));
    ext0_lvl[2] = 1'b0;
    cyc(4);
    chk("level low", 8'h00, 8'(irq_a_req));
    ext0_en = 8'h00;
    wr(pimc_pkg::ADDR_IRQ_CFG, 8'h00);
    lvl_start = 1'b1;
    cyc(1);
    lvl_start = 1'b0;
    cyc(4);
    chk("level source", 8'h01, 8'(irq_a_req));
    chk("level source b", 8'h01, 8'(irq_b_req));
    pulse_ack();
    cyc(4);
    chk("source released", 8'h00, 8'(irq_a_req));
    chk("released b", 8'h00, 8'(irq_b_req));
    ext0_en = 8'h08;
    ext0_lvl = 8'h00;
    wr(pimc_pkg::ADDR_CMP_SEL0, 8'h08);
    cyc(3);
    chk("mismatch", 8'h01, 8'(mism));
    wr(pimc_pkg::ADDR_EXP_VAL0, 8'hf7);
    cyc(3);
    chk("match", 8'h00, 8'(mism));
    rd(pimc_pkg::ADDR_PORT0, 1'b0, 8'hf7, "pin read");
    rd(pimc_pkg::ADDR_PORT0, 1'b1, 8'hff, "rmw read");
    wr(pimc_pkg::ADDR_PORT0, 8'h0f);
    cyc(2);
    chk("oe master off", 8'hff, p0_oe_n);
    wr(pimc_pkg::ADDR_XBAR_C, 8'h40);
    cyc(2);
    chk("oe master on", 8'h0f, p0_oe_n);
    cyc(3);
    rd(pimc_pkg::ADDR_PORT0, 1'b0, 8'h07, "driven pins");
    wr(pimc_pkg::ADDR_PORT0, 8'hff);
    wr(pimc_pkg::ADDR_XBAR_A, 8'h01);
    ext0_en = 8'h20;
    cyc(4);
    chk("uart tx", 8'h00, 8'({p0_oe_n[4], p0_out[4]}));
    chk("uart rx", 8'h00, 8'(uart_rx));
    pr.spi_a_nss_out = 1'b1;
    wr(pimc_pkg::ADDR_XBAR_A, 8'h02);
    cyc(2);
    chk("spi a 4", 8'h04, 8'(spi_cnt));
    chk("route a", 8'h02, route_a);
    pr.spi_a_nss_out = 1'b0;
    cyc(2);
    chk("spi a 3", 8'h03, 8'(spi_cnt));
    ext1_en = 8'h02;
    wr(pimc_pkg::ADDR_XBAR_B, 8'h40);
    cyc(4);
    chk("spi b 3w", 8'h02, 8'({p1_oe_n[3], p1_oe_n[0]}));
    chk("spi b miso", 8'h00, 8'(spi_b_miso));
    chk("route b", 8'h40, route_b);
    pr.spi_b_four_wire = 1'b1;
    cyc(2);
    chk("spi b 4w", 8'h00, 8'(p1_oe_n[3]));
    cyc(2);
    rd(pimc_pkg::ADDR_PORT1, 1'b0, 8'hf0, "p1 pins");
    rd(pimc_pkg::ADDR_PORT1, 1'b1, 8'hff, "p1 latch");
    wr(pimc_pkg::ADDR_XBAR_C, 8'h80);
    cyc(2);
    chk("pullup off", 8'h02, 8'({pu_off, mst}));
    chk("oe off", 8'hff, p0_oe_n);
    give_verdict();
  end
endmodule // tb_port_irq_match_crossbar
